// File: scc_params.svh
// Register map constants, strap addresses and port counts for the serializer core control registers
`ifndef SCC_PARAMS_SVH
`define SCC_PARAMS_SVH
`define SCC_OFS_BUS_ADDRESS   8'h00
`define SCC_OFS_SLEEP_RESET   8'h01
`define SCC_OFS_GEN_CONFIG    8'h03
`define SCC_BIT_ADDR_SRC      0
`define SCC_BIT_SLEEP         7
`define SCC_BIT_FULL_RST      1
`define SCC_BIT_CORE_RST      0
`define SCC_BIT_CRC_EN        7
`define SCC_BIT_RSVD_ONE      6
`define SCC_BIT_AUTO_ACK      5
`define SCC_BIT_FILTER        4
`define SCC_BIT_PASS_THRU     3
`define SCC_BIT_PCLK_AUTO     1
`define SCC_GEN_CONFIG_RESET  8'hd2
`define SCC_STRAP_BASE_ADDR   7'h0c
`define SCC_STRAP_ADDR_STEP   7'h02
`define SCC_NUM_PORTS         2
`define SCC_NUM_SYNC_IN       3
`endif

// File: scc_pkg.sv
// Types shared by the serializer core control registers
package scc_pkg;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } scc_req_t;
  typedef struct packed {
    logic de;
    logic hs;
    logic vs;
  } scc_sync_t;
endpackage

// File: scc_core_regs.sv
// Core control and configuration registers of the video serializer
`include "scc_params.svh"
`timescale 1ns/1ns
`default_nettype none
module scc_core_regs
(
  input  wire logic              CLK,
  input  wire logic              RST_N,
  input  wire logic              CE,
  input  wire scc_pkg::scc_req_t REG_REQ,
  output logic [7:0]             REG_RDATA,
  input  wire logic [2:0]        ADDRESS_STRAP_PIN,
  input  wire logic              SECOND_PORT_ADDRESS_ENABLE,
  input  wire logic              SECOND_PORT_VIEW_SELECT,
  input  wire logic              BCC_LINK_UP,
  input  wire logic              PCLK_PRESENT,
  input  wire logic [1:0]        ALIAS_MATCH,
  input  wire logic [1:0]        REMOTE_NACK,
  input  wire scc_pkg::scc_sync_t SYNC_IN,
  output scc_pkg::scc_sync_t     SYNC_OUT,
  output logic [6:0]             DEV_ADDR,
  output logic [6:0]             DEV_ADDR1,
  output logic                   DEV_ADDR1_EN,
  output logic                   STRAP_DONE,
  output logic                   POWER_DOWN,
  output logic                   CORE_RST,
  output logic                   CRC_CHK_EN,
  output logic [1:0]             AUTO_ACK,
  output logic [1:0]             LOCAL_NACK,
  output logic [1:0]             FORWARD,
  output logic                   USE_INT_OSC
);
  import scc_pkg::*;

  logic [2:0] strap_s1;
  logic [2:0] strap_s2;
  logic [2:0] strap_s3;
  logic [6:0] strap_addr;
  logic       strap_done;
  logic [6:0] addr_fld [`SCC_NUM_PORTS];
  logic       addr_src;
  logic       sleep;
  logic       full_rst;
  logic       core_rst;
  logic       crc_en;
  logic [1:0] auto_ack;
  logic [1:0] pass_thru;
  logic       filter_en;
  logic       pclk_auto;
  logic       sel;
  logic       wr_addr;
  logic       wr_reset;
  logic       wr_cfg;
  logic [7:0] next_rdata;
  logic [6:0] strap_code;
  logic [2:0] strap_fill;
  logic       strap_take;
  localparam logic [7:0] cfg_reset = `SCC_GEN_CONFIG_RESET;

  assign sel      = SECOND_PORT_VIEW_SELECT;
  assign wr_addr  = REG_REQ.wr && REG_REQ.addr == `SCC_OFS_BUS_ADDRESS;
  assign wr_reset = REG_REQ.wr && REG_REQ.addr == `SCC_OFS_SLEEP_RESET;
  assign wr_cfg   = REG_REQ.wr && REG_REQ.addr == `SCC_OFS_GEN_CONFIG;

  // Async strap; taken once the last two stages agree and hold real samples, not reset zeros
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      strap_s1 <= 3'h0;
      strap_s2 <= 3'h0;
      strap_s3 <= 3'h0;
      strap_fill <= 3'h0;
    end
    else if (CE)
    begin
      strap_s1 <= ADDRESS_STRAP_PIN;
      strap_s2 <= strap_s1;
      strap_s3 <= strap_s2;
      strap_fill <= {strap_fill[1:0], 1'b1};
    end
  end

  // Eight strap levels map to evenly spaced addresses
  assign strap_code = {4'h0, strap_s3} * `SCC_STRAP_ADDR_STEP;
  assign strap_take = !strap_done && strap_fill[2] && strap_s2 == strap_s3;

  // Caught once after release; a full soft reset keeps the captured strap
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      strap_addr <= 7'h00;
      strap_done <= 1'b0;
    end
    else if (CE && strap_take)
    begin
      strap_addr <= `SCC_STRAP_BASE_ADDR + strap_code;
      strap_done <= 1'b1;
    end
  end

  // Self-clearing reset pulses, one cycle after the write
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      full_rst <= 1'b0;
      core_rst <= 1'b0;
    end
    else if (CE)
    begin
      full_rst <= wr_reset && REG_REQ.wdata[`SCC_BIT_FULL_RST];
      core_rst <= wr_reset && (REG_REQ.wdata[`SCC_BIT_CORE_RST] ||
                               REG_REQ.wdata[`SCC_BIT_FULL_RST]);
    end
  end

  // Address fields follow the strap until software picks its own
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      addr_fld[0] <= 7'h00;
      addr_fld[1] <= 7'h00;
      addr_src    <= 1'b0;
    end
    else if (CE)
    begin
      if (full_rst || strap_take)
      begin
        addr_fld[0] <= full_rst ? strap_addr : `SCC_STRAP_BASE_ADDR + strap_code;
        addr_fld[1] <= full_rst ? strap_addr + 7'h01 :
                       `SCC_STRAP_BASE_ADDR + strap_code + 7'h01;
        addr_src    <= 1'b0;
      end
      else if (wr_addr)
      begin
        addr_fld[sel] <= REG_REQ.wdata[7:1];
        addr_src      <= REG_REQ.wdata[`SCC_BIT_ADDR_SRC];
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      sleep <= 1'b0;
    else if (CE)
    begin
      if (full_rst)
        sleep <= 1'b0;
      else if (wr_reset)
        sleep <= REG_REQ.wdata[`SCC_BIT_SLEEP];
    end
  end

  // Reset values give checker, filter and clock auto-switch on
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      crc_en    <= cfg_reset[`SCC_BIT_CRC_EN];
      filter_en <= cfg_reset[`SCC_BIT_FILTER];
      pclk_auto <= cfg_reset[`SCC_BIT_PCLK_AUTO];
      auto_ack  <= 2'h0;
      pass_thru <= 2'h0;
    end
    else if (CE)
    begin
      if (full_rst)
      begin
        crc_en    <= cfg_reset[`SCC_BIT_CRC_EN];
        filter_en <= cfg_reset[`SCC_BIT_FILTER];
        pclk_auto <= cfg_reset[`SCC_BIT_PCLK_AUTO];
        auto_ack  <= 2'h0;
        pass_thru <= 2'h0;
      end
      else if (wr_cfg)
      begin
        crc_en         <= REG_REQ.wdata[`SCC_BIT_CRC_EN];
        filter_en      <= REG_REQ.wdata[`SCC_BIT_FILTER];
        pclk_auto      <= REG_REQ.wdata[`SCC_BIT_PCLK_AUTO];
        auto_ack[sel]  <= REG_REQ.wdata[`SCC_BIT_AUTO_ACK];
        pass_thru[sel] <= REG_REQ.wdata[`SCC_BIT_PASS_THRU];
      end
    end
  end

  // Read mux; unmapped offsets and reserved bits read zero, except config bit 6 which reads one
  always_comb
  begin
    next_rdata = 8'h00;
    case (REG_REQ.addr)
      `SCC_OFS_BUS_ADDRESS: next_rdata = {addr_fld[sel], addr_src};
      `SCC_OFS_SLEEP_RESET: next_rdata = {sleep, 7'h00};
      `SCC_OFS_GEN_CONFIG:
      begin
        next_rdata[`SCC_BIT_CRC_EN]    = crc_en;
        next_rdata[`SCC_BIT_RSVD_ONE]  = 1'b1;
        next_rdata[`SCC_BIT_AUTO_ACK]  = auto_ack[sel];
        next_rdata[`SCC_BIT_FILTER]    = filter_en;
        next_rdata[`SCC_BIT_PASS_THRU] = pass_thru[sel];
        next_rdata[`SCC_BIT_PCLK_AUTO] = pclk_auto;
      end
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      REG_RDATA <= 8'h00;
    else if (CE && REG_REQ.rd)
      REG_RDATA <= next_rdata;
  end

  // Two-clock pulse filter; cleared by the datapath reset
  logic [2:0] sync_prev;
  logic [2:0] sync_q;
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      sync_prev <= 3'h0;
      sync_q    <= 3'h0;
    end
    else if (CE)
    begin
      if (core_rst)
      begin
        sync_prev <= 3'h0;
        sync_q    <= 3'h0;
      end
      else
      begin
        sync_prev <= SYNC_IN;
        for (int i = 0; i < `SCC_NUM_SYNC_IN; i++)
          if (!filter_en || SYNC_IN[i] == sync_prev[i])
            sync_q[i] <= SYNC_IN[i];
      end
    end
  end
  assign SYNC_OUT = sync_q;

  assign DEV_ADDR     = addr_src ? addr_fld[0] : strap_addr;
  assign DEV_ADDR1    = addr_src ? addr_fld[1] : strap_addr + 7'h01;
  assign DEV_ADDR1_EN = SECOND_PORT_ADDRESS_ENABLE;
  assign STRAP_DONE   = strap_done;
  assign POWER_DOWN   = sleep && !BCC_LINK_UP;
  assign CORE_RST     = core_rst;
  assign CRC_CHK_EN   = crc_en;
  assign AUTO_ACK     = auto_ack;
  assign LOCAL_NACK   = REMOTE_NACK & ~auto_ack;
  assign FORWARD      = pass_thru & ALIAS_MATCH;
  assign USE_INT_OSC  = pclk_auto && !PCLK_PRESENT;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N || !CE);

  sequence s_wr_core;
    wr_reset && REG_REQ.wdata[`SCC_BIT_CORE_RST] && !REG_REQ.wdata[`SCC_BIT_FULL_RST];
  endsequence
  sequence s_pulse_once;
    CORE_RST ##1 !CORE_RST;
  endsequence
  sequence s_wr_full;
    wr_reset && REG_REQ.wdata[`SCC_BIT_FULL_RST];
  endsequence

  a_core_rst_pulse: assert property (s_wr_core ##1 !wr_reset |-> s_pulse_once)
    else $error("datapath reset did not pulse once");
  a_core_keeps_regs: assert property (s_wr_core ##1 !wr_cfg |=> $stable(crc_en))
    else $error("datapath reset changed a register");
  a_full_rst_defaults: assert property (s_wr_full ##1 !wr_cfg
                                        |=> crc_en && filter_en && pclk_auto)
    else $error("full reset did not restore defaults");
  a_addr_source: assert property (strap_done && !addr_src |-> DEV_ADDR == strap_addr)
    else $error("bus address not taken from strap");
  a_port1_addr: assert property (!addr_src |-> DEV_ADDR1 == DEV_ADDR + 7'h01)
    else $error("second port address not strap plus one");
  a_sleep_power: assert property (POWER_DOWN |-> sleep && !BCC_LINK_UP)
    else $error("power down without idle condition");
  a_nack_block: assert property (auto_ack[0] |-> !LOCAL_NACK[0])
    else $error("remote nack leaked under auto acknowledge");
  a_filter_glitch: assert property ($changed(sync_q[0]) && $past(filter_en && !core_rst)
                                    |-> $past(SYNC_IN[0]) == $past(sync_prev[0]))
    else $error("short pulse passed the filter");
  a_forward_gate: assert property (FORWARD[1] |-> pass_thru[1] && ALIAS_MATCH[1])
    else $error("forward without pass through");
  a_osc_switch: assert property (USE_INT_OSC |-> pclk_auto && !PCLK_PRESENT)
    else $error("oscillator switch while disabled");
  a_view_write: assert property (wr_cfg && sel && !full_rst
                                 |=> auto_ack[0] == $past(auto_ack[0]))
    else $error("second port view wrote first port copy");
endmodule
`default_nettype wire

// File: scc_host.sv
// Host-side model issuing single-byte register requests
`timescale 1ns/1ns
`default_nettype none
module scc_host
(
  input  wire logic             CLK,
  output var scc_pkg::scc_req_t REQ,
  input  wire logic [7:0]       RDATA
);
  import scc_pkg::*;
  initial REQ = '0;
  // Held from one edge to the taking edge; data is read once that edge lands
  task automatic access(input logic w, input logic [7:0] a, d, output logic [7:0] q);
    @(posedge CLK);
    REQ <= {w, !w, a, d};
    @(posedge CLK);
    REQ <= '0;
    #1 q = RDATA;
  endtask
endmodule
`default_nettype wire

// File: serializer_core_control_regs_test.sv
// Self-checking bench for the serializer core control registers
`timescale 1ns/1ns
`default_nettype none
module serializer_core_control_regs_test;
  import scc_pkg::*;
  logic            clk, rst_n, ce, p1_en, view, link, pclk, en1, sdone, pdn, crst, crc_o, osc;
  logic [2:0]      strap;
  logic [1:0]      al, rn, aa_o, nk_o, fw_o, aa, ps;
  logic [7:0]      rdata, q;
  logic [6:0]      dev0, dev1, a0, a1, base;
  logic            src, slp, crc, flt, pa;
  scc_req_t        req;
  scc_sync_t       sin, sout;
  int              n_mismatch, n_checks, cnt;

  scc_core_regs DUT
  (
    .CLK(clk), .RST_N(rst_n), .CE(ce), .REG_REQ(req), .REG_RDATA(rdata),
    .ADDRESS_STRAP_PIN(strap), .SECOND_PORT_ADDRESS_ENABLE(p1_en),
    .SECOND_PORT_VIEW_SELECT(view),
    .BCC_LINK_UP(link), .PCLK_PRESENT(pclk), .ALIAS_MATCH(al), .REMOTE_NACK(rn),
    .SYNC_IN(sin), .SYNC_OUT(sout), .DEV_ADDR(dev0), .DEV_ADDR1(dev1),
    .DEV_ADDR1_EN(en1), .STRAP_DONE(sdone), .POWER_DOWN(pdn), .CORE_RST(crst),
    .CRC_CHK_EN(crc_o), .AUTO_ACK(aa_o), .LOCAL_NACK(nk_o), .FORWARD(fw_o),
    .USE_INT_OSC(osc)
  );
  scc_host host (.CLK(clk), .REQ(req), .RDATA(rdata));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // About four times the expected run
  initial
  begin
    #60000;
    n_mismatch++;
    finish_test();
  end

  task chk(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task defaults;
    {a0, a1} = {base, base + 7'h01};
    {src, slp, crc, flt, pa, aa, ps} = 9'b0_0_1_1_1_00_00;
  endtask
  function automatic logic [7:0] rexp(input logic [7:0] a);
    if (a == 8'h00) return {view ? a1 : a0, src};
    if (a == 8'h01) return {slp, 7'h00};
    if (a == 8'h03) return {crc, 1'b1, aa[view], flt, ps[view], 1'b0, pa, 1'b0};
    return 8'h00;
  endfunction
  task rd(input logic [7:0] a);
    host.access(1'b0, a, 8'h00, q);
    chk(q, rexp(a));
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    host.access(1'b1, a, d, q);
    cnt = int'(crst);
    repeat (2)
    begin
      @(posedge clk);
      #1 cnt += int'(crst);
    end
    chk(8'(cnt), 8'(a == 8'h01 && d[1:0] != 2'b00));
    if (a == 8'h00) {a1, a0, src} = view ? {d[7:1], a0, d[0]} : {a1, d[7:1], d[0]};
    if (a == 8'h01) slp = d[7];
    if (a == 8'h01 && d[1]) defaults();
    if (a == 8'h03) {crc, flt, pa} = {d[7], d[4], d[1]};
    if (a == 8'h03) aa[view] = d[5];
    if (a == 8'h03) ps[view] = d[3];
  endtask
  task outs;
    @(posedge clk);
    {link, pclk, al, rn} <= 6'($urandom);
    @(posedge clk);
    #1;
    chk(8'(dev0), 8'(src ? a0 : base));
    chk(8'(dev1), 8'(src ? a1 : base + 7'h01));
    chk(8'(en1), 8'(p1_en));
    chk(8'(pdn), 8'(slp && !link));
    chk(8'(crc_o), 8'(crc));
    chk(8'(aa_o), 8'(aa));
    chk(8'(nk_o), 8'(rn & ~aa));
    chk(8'(fw_o), 8'(al & ps));
    chk(8'(osc), 8'(pa && !pclk));
  endtask
  task pulse(input int len);
    logic [2:0] seen;
    seen = 3'b000;
    @(posedge clk);
    sin <= 3'b111;
    for (int i = 0; i < len + 5; i++)
    begin
      @(posedge clk);
      if (i == len - 1) sin <= 3'b000;
      #1 seen |= sout;
    end
    chk(8'(seen), (flt && len < 2) ? 8'h00 : 8'h07);
  endtask

  initial
  begin
    void'($urandom(9));
    {rst_n, p1_en, view, link, pclk, al, rn, sin} = 12'h040;
    strap = 3'($urandom);
    n_mismatch = 0;
    n_checks = 0;
    ce = 1'b1;
    base = 7'h0c + 7'h02 * strap;
    defaults();
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    #1 chk(8'(sdone), 8'h01);
    rd(8'h00);
    rd(8'h01);
    rd(8'h02);
    rd(8'h03);
    outs();
    pulse(1);
    pulse(3);
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clk);
      p1_en <= 1'($urandom);
      view <= i[0];
      wr(8'h00, 8'($urandom));
      wr(8'h03, 8'($urandom));
      wr(8'h01, 8'($urandom) & 8'h80);
      rd(8'h00);
      rd(8'h01);
      rd(8'h03);
      outs();
      pulse(1);
    end
    // A write offered while the enable is low must leave the register untouched
    @(posedge clk);
    ce <= 1'b0;
    host.access(1'b1, 8'h03, 8'h00, q);
    @(posedge clk);
    ce <= 1'b1;
    rd(8'h03);
    wr(8'h01, 8'h81);
    rd(8'h03);
    rd(8'h00);
    wr(8'h01, 8'h02);
    rd(8'h00);
    rd(8'h01);
    rd(8'h03);
    outs();
    finish_test();
  end
endmodule
`default_nettype wire
